// >>> common/iacu_defs.svh
// register offsets, field positions and reset values of the fetch compare unit
`ifndef IACU_DEFS_SVH
`define IACU_DEFS_SVH
`define IACU_OFF_CTRL0 12'h000
`define IACU_OFF_CTRL1 12'h004
`define IACU_OFF_STAT 12'h008
`define IACU_OFF_CMP1 12'h00C
`define IACU_OFF_CMP2 12'h010
`define IACU_OFF_CMP3 12'h014
`define IACU_OFF_CMP4 12'h018
`define IACU_OFF_MASK 12'h01C
`define IACU_CTRL0_EN_LSB 0
`define IACU_CTRL1_MODE_A_LSB 0
`define IACU_CTRL1_MODE_B_LSB 2
`define IACU_CTRL1_TGL_A_BIT 4
`define IACU_CTRL1_TGL_B_BIT 5
`define IACU_CTRL1_PRIV_LSB 8
`define IACU_CTRL1_SPACE_LSB 16
`define IACU_STAT_HIT_LSB 0
`define IACU_STAT_TS_A_BIT 4
`define IACU_STAT_TS_B_BIT 5
`define IACU_STAT_W 6
`define IACU_RST_WORD 32'h0000_0000
`define IACU_MODE_EXACT 2'h0
`define IACU_MODE_INCL 2'h2
`define IACU_MODE_EXCL 2'h3
`define IACU_QUAL_ANY 2'h0
`define IACU_QUAL_ZERO 2'h2
`define IACU_QUAL_ONE 2'h3
`endif

// >>> common/iacu_pkg.sv
// types shared by the fetch compare unit
package iacu_pkg;
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic problem_state_bit;
		logic instr_space_bit;
	} iacu_fetch_t;
	typedef struct packed {
		logic [1:0] space_qual;
		logic [1:0] priv_qual;
	} iacu_qual_t;
endpackage : iacu_pkg

// >>> hdl/iacu_top.sv
// instruction fetch address compare unit with apb register slave
// Summary of operation
// R1 - a compare event fires only with its enable bit set; then its status sets
// R2 - mode 00: each comparator matches on exact address equality
// R3 - mode 10: pair matches when first <= address < second
// R4 - mode 11: pair matches when address < first or address >= second
// R5 - range match sets only those pair status bits whose enables are set
// R6 - software must not program mode 01, it is reserved
// R7 - software enables at least one event of a pair in range mode
// R8 - privilege qualifier: 00 any, 10 supervisor, 11 user
// R9 - space qualifier: 00 any, 10 space zero, 11 space one
// R10 - process identifier is ignored, only address, space bit and problem state bit compared
// R11 - software sets equal privilege qualifiers for a pair in range mode
// R12 - software sets equal space qualifiers for a pair in range mode
// R13 - toggle enable bit of a pair allows inclusive/exclusive switching
// R14 - software sets toggle enable only with a range mode selected
// R15 - with toggle enabled, each pair event flips its toggle status bit
// R16 - toggle status one swaps meaning of mode 10 and 11
// R17 - range compares are unsigned over the full address width
`timescale 1ns/1ps
`include "iacu_defs.svh"
module iacu_top #(
	parameter int AW = 32
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire iacu_pkg::iacu_fetch_t i_fetch,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [3:0] o_hit,
	output logic o_irq
);
	logic [31:0] ctrl0_q;
	logic [31:0] ctrl1_q;
	logic [31:0] mask_q;
	logic [`IACU_STAT_W-1:0] stat_q;
	logic [`IACU_STAT_W-1:0] stat_d;
	logic [AW-1:0] cmp_q [4];
	logic [3:0] qual_ok;
	logic [3:0] exact_hit;
	logic [3:0] ev;
	logic [1:0] pair_ev;
	logic [1:0] tgl_en;
	logic [1:0] tgl_st;
	logic [AW-1:0] fa;
	logic wr_acc;
	logic rd_acc;
	logic addr_ok;
	logic [31:0] rdata;

	assign fa = i_fetch.addr[AW-1:0];
	assign tgl_en = {ctrl1_q[`IACU_CTRL1_TGL_B_BIT],
		ctrl1_q[`IACU_CTRL1_TGL_A_BIT]};
	assign tgl_st = {stat_q[`IACU_STAT_TS_B_BIT], stat_q[`IACU_STAT_TS_A_BIT]};

	// one-wait apb slave: setup, then access answered on its second cycle
	assign wr_acc = i_psel & i_penable & i_pwrite & ~o_pready;
	assign rd_acc = i_psel & i_penable & ~i_pwrite & ~o_pready;

	// per comparator: qualifiers and exact equality
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_cmp
			iacu_pkg::iacu_qual_t q;
			logic priv_ok;
			logic space_ok;
			assign q.priv_qual = ctrl1_q[`IACU_CTRL1_PRIV_LSB + 2*g +: 2];
			assign q.space_qual = ctrl1_q[`IACU_CTRL1_SPACE_LSB + 2*g +: 2];
			// reserved 01 never matches so a bad setting stays quiet
			always_comb begin
				unique case (q.priv_qual)
					`IACU_QUAL_ANY: priv_ok = 1'b1; // R8
					`IACU_QUAL_ZERO: priv_ok = ~i_fetch.problem_state_bit; // R8
					`IACU_QUAL_ONE: priv_ok = i_fetch.problem_state_bit; // R8
					default: priv_ok = 1'b0;
				endcase
			end
			// only the effective address, the space bit and the problem state bit take part R10
			always_comb begin
				unique case (q.space_qual)
					`IACU_QUAL_ANY: space_ok = 1'b1; // R9
					`IACU_QUAL_ZERO: space_ok = ~i_fetch.instr_space_bit; // R9
					`IACU_QUAL_ONE: space_ok = i_fetch.instr_space_bit; // R9
					default: space_ok = 1'b0;
				endcase
			end
			assign qual_ok[g] = priv_ok & space_ok;
			assign exact_hit[g] = (fa == cmp_q[g]); // R2
		end
	endgenerate

	// per pair: mode decode with toggle swap, then range match
	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_pair
			logic [1:0] mode;
			logic in_rng;
			logic swap;
			logic incl;
			logic rng_hit;
			logic pq;
			// one local vector per pair keeps ev to a single writer process
			logic [1:0] ev_p;
			assign mode = ctrl1_q[`IACU_CTRL1_MODE_A_LSB + 2*p +: 2];
			assign swap = tgl_en[p] & tgl_st[p]; // R13 R16
			assign incl = (mode == `IACU_MODE_INCL) ^ swap; // R16
			// unsigned compare on the whole width R17
			assign in_rng = (cmp_q[2*p] <= fa) && (fa < cmp_q[2*p+1]); // R3
			// pair qualifiers are equal by software contract R11 R12
			assign pq = qual_ok[2*p];
			assign rng_hit = pq & (incl ? in_rng : ~in_rng); // R3 R4
			always_comb begin
				unique case (mode)
					`IACU_MODE_EXACT: begin
						ev_p[0] = exact_hit[2*p] & qual_ok[2*p]; // R2
						ev_p[1] = exact_hit[2*p+1] & qual_ok[2*p+1]; // R2
					end
					`IACU_MODE_INCL, `IACU_MODE_EXCL: begin
						ev_p[0] = rng_hit; // R5
						ev_p[1] = rng_hit; // R5
					end
					// reserved mask mode raises nothing R6
					default: begin
						ev_p = 2'h0;
					end
				endcase
			end
			assign ev[2*p +: 2] = ev_p;
		end
	endgenerate

	// final gate by fetch valid and per-event enables
	logic [3:0] fire;
	assign fire = ev & {4{i_fetch.valid}} &
		ctrl0_q[`IACU_CTRL0_EN_LSB +: 4]; // R1 R5
	assign pair_ev = {|fire[3:2], |fire[1:0]};

	// status: hardware set beats write-one-to-clear in the same cycle
	always_comb begin
		stat_d = stat_q;
		if (wr_acc && i_paddr == `IACU_OFF_STAT) begin
			stat_d = stat_q & ~i_pwdata[`IACU_STAT_W-1:0];
		end
		stat_d[`IACU_STAT_HIT_LSB +: 4] = stat_d[`IACU_STAT_HIT_LSB +: 4] |
			fire; // R1
		// toggle flips with the event itself, relative to pre-event value
		if (tgl_en[0] && pair_ev[0]) begin
			stat_d[`IACU_STAT_TS_A_BIT] = ~tgl_st[0]; // R15
		end
		if (tgl_en[1] && pair_ev[1]) begin
			stat_d[`IACU_STAT_TS_B_BIT] = ~tgl_st[1]; // R15
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			stat_q <= '0;
		end else begin
			stat_q <= stat_d;
		end
	end

	// software written control and compare registers
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl0_q <= `IACU_RST_WORD;
			ctrl1_q <= `IACU_RST_WORD;
			mask_q <= `IACU_RST_WORD;
			for (int i = 0; i < 4; i++) begin
				cmp_q[i] <= '0;
			end
		end else if (wr_acc) begin
			unique case (i_paddr)
				`IACU_OFF_CTRL0: ctrl0_q <= i_pwdata & 32'h0000_000F;
				`IACU_OFF_CTRL1: ctrl1_q <= i_pwdata & 32'h00FF_FF3F;
				`IACU_OFF_MASK: mask_q <= i_pwdata & 32'h0000_003F;
				`IACU_OFF_CMP1: cmp_q[0] <= i_pwdata[AW-1:0];
				`IACU_OFF_CMP2: cmp_q[1] <= i_pwdata[AW-1:0];
				`IACU_OFF_CMP3: cmp_q[2] <= i_pwdata[AW-1:0];
				`IACU_OFF_CMP4: cmp_q[3] <= i_pwdata[AW-1:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		addr_ok = 1'b1;
		rdata = '0;
		unique case (i_paddr)
			`IACU_OFF_CTRL0: rdata = ctrl0_q;
			`IACU_OFF_CTRL1: rdata = ctrl1_q;
			`IACU_OFF_STAT: rdata[`IACU_STAT_W-1:0] = stat_q;
			`IACU_OFF_MASK: rdata = mask_q;
			`IACU_OFF_CMP1: rdata = 32'(cmp_q[0]);
			`IACU_OFF_CMP2: rdata = 32'(cmp_q[1]);
			`IACU_OFF_CMP3: rdata = 32'(cmp_q[2]);
			`IACU_OFF_CMP4: rdata = 32'(cmp_q[3]);
			default: addr_ok = 1'b0;
		endcase
	end

	// bus answer registered: pready one cycle into access phase
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= '0;
		end else begin
			o_pready <= wr_acc | rd_acc;
			o_pslverr <= (wr_acc | rd_acc) & ~addr_ok;
			o_prdata <= rd_acc ? rdata : 32'h0000_0000;
		end
	end

	// event pulses and interrupt out of flops
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_hit <= 4'h0;
			o_irq <= 1'b0;
		end else begin
			o_hit <= fire;
			o_irq <= |(stat_d & mask_q[`IACU_STAT_W-1:0]);
		end
	end
endmodule : iacu_top

// >>> tb/iacu_top_asserts.sv
// port assertions for the fetch compare unit
`timescale 1ns/1ps
module iacu_chk (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire iacu_pkg::iacu_fetch_t i_fetch,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [3:0] o_hit,
	input wire logic o_irq
);
	logic [3:0] en_q;
	logic act;
	assign act = |o_hit || i_psel;
	// shadow of the event enables, written from the bus
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn)
			en_q <= 4'h0;
		else if (i_psel && i_penable && i_pwrite && i_paddr == 12'h000)
			en_q <= i_pwdata[3:0];
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	sequence s_acc;
		i_psel && i_penable && !o_pready;
	endsequence
	a_ready_next: assert property (s_acc |=> o_pready)
		else $error("no ready after access");
	a_ready_one: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data outside answer");
	a_hit_fetch: assert property (o_hit != 4'h0 |-> $past(i_fetch.valid))
		else $error("hit without fetch");
	a_hit_enabled: assert property ((o_hit & ~$past(en_q)) == 4'h0)
		else $error("hit on disabled event");
	a_irq_rise: assert property ($rose(o_irq) |-> act || $past(act))
		else $error("irq rose without cause");
	a_irq_fall: assert property ($fell(o_irq) |-> $past(i_psel) || $past(i_psel, 2))
		else $error("irq fell without write");
endmodule : iacu_chk

// >>> tb/iacu_fetch_mdl.sv
// fetch pipeline model issuing one attempted fetch at a time
`timescale 1ns/1ps
module iacu_fetch_mdl (
	input wire logic i_ref_clk,
	output iacu_pkg::iacu_fetch_t o_fetch
);
	initial o_fetch = '0;
	task automatic issue(input logic [31:0] a, input logic pr, sp);
		@(posedge i_ref_clk);
		o_fetch <= '{1'h1, a, pr, sp};
		@(posedge i_ref_clk);
		// idle lines show the inverse so a stale address cannot match
		o_fetch <= '{1'h0, ~a, ~pr, ~sp};
	endtask : issue
endmodule : iacu_fetch_mdl

// >>> tb/iacu_top_test.sv
// self-checking bench for the fetch compare unit
`timescale 1ns/1ps
module iacu_top_test;
	logic i_ref_clk = 1'h0, i_rstn = 1'h0, i_psel = 1'h0;
	logic i_penable = 1'h0, i_pwrite = 1'h0, o_pready, o_pslverr, o_irq, rd_err;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0, o_prdata, rd_data;
	logic [31:0] ad [4] = '{32'hFF, 32'h100, 32'h8000_0000, 32'h9000_0000};
	logic [3:0] o_hit;
	iacu_pkg::iacu_fetch_t i_fetch;
	int error_cnt = 0, checks = 0;
	iacu_top dut_u (.i_ref_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .i_fetch, .o_prdata, .o_pready, .o_pslverr,
		.o_hit, .o_irq);
	iacu_fetch_mdl fm_u (.i_ref_clk, .o_fetch(i_fetch));
	initial begin
		forever #50 i_ref_clk = ~i_ref_clk;
	end
	task automatic chk(input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_ref_clk);
		i_penable <= 1'h1;
		do @(posedge i_ref_clk); while (o_pready !== 1'h1);
		rd_data = o_prdata;
		rd_err = o_pslverr;
		i_psel <= 1'h0;
		i_penable <= 1'h0;
	endtask : bus
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(rd_data, e);
	endtask : rdc
	task automatic fc(input logic [31:0] a, input logic pr, sp, input logic [3:0] e);
		fm_u.issue(a, pr, sp);
		#1;
		chk({28'h0, o_hit}, {28'h0, e});
	endtask : fc
	task automatic end_sim;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		#1_000_000;
		error_cnt++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge i_ref_clk);
		i_rstn <= 1'h1;
		for (int k = 0; k < 8; k++) rdc(12'(4 * k), 32'h0);
		rdc(12'h020, 32'h0);
		chk({31'h0, rd_err}, 32'h1);
		for (int k = 0; k < 4; k++) bus(1'h1, 12'(12 + 4 * k), 32'h100 * (k + 1));
		bus(1'h1, 12'h000, 32'hD);
		fc(32'h200, 1'h0, 1'h0, 4'h0);
		fc(32'h300, 1'h0, 1'h0, 4'h4);
		bus(1'h1, 12'h000, 32'hF);
		for (int f = 0; f < 2; f++)
			for (int q = 0; q < 4; q++)
				for (int b = 0; b < 2; b++) begin
					bus(1'h1, 12'h004, 32'(q) << (8 + 8 * f));
					fc(32'h100, b[0] && f == 0, b[0] && f == 1,
						{3'h0, q == 0 || q[1] && q[0] == b[0]});
				end
		bus(1'h1, 12'h010, 32'h9000_0000);
		for (int m = 2; m < 4; m++) begin
			bus(1'h1, 12'h000, 32'(m - 1));
			bus(1'h1, 12'h004, 32'(m));
			foreach (ad[i]) fc(ad[i], 1'h0, 1'h0,
				((i == 1 || i == 2) ^ (m == 3)) ? 4'(m - 1) : 4'h0);
		end
		bus(1'h1, 12'h000, 32'h1);
		bus(1'h1, 12'h008, 32'h3F);
		bus(1'h1, 12'h01C, 32'h1);
		bus(1'h1, 12'h004, 32'h12);
		fc(32'h100, 1'h0, 1'h0, 4'h1);
		rdc(12'h008, 32'h11);
		chk({31'h0, o_irq}, 32'h1);
		fc(32'h100, 1'h0, 1'h0, 4'h0);
		fc(32'h050, 1'h0, 1'h0, 4'h1);
		rdc(12'h008, 32'h01);
		bus(1'h1, 12'h01C, 32'h0);
		#1 chk({31'h0, o_irq}, 32'h0);
		bus(1'h1, 12'h008, 32'h1);
		rdc(12'h008, 32'h0);
		end_sim();
	end
endmodule : iacu_top_test
bind iacu_top iacu_chk chk_u (.i_ref_clk, .i_rstn, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .i_fetch, .o_prdata, .o_pready,
	.o_pslverr, .o_hit, .o_irq);
